// File: core/dvs_pin_sync.sv
// two flip-flop synchroniser for the serial and sleep pins
// assumes an already synchronised active-low reset
`timescale 1ns/1ps
module dvs_pin_sync
   import dvs_pkg::*;
(
   input  wire logic             i_core_clk,
   input  wire logic             i_rst_n,
   input  wire logic [PIN_W-1:0] i_async,
   output logic      [PIN_W-1:0] o_sync
);

   genvar g;
   generate
      for (g = 0; g < PIN_W; g++) begin : g_lane
         logic meta;
         logic held;
         always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               meta <= PIN_RST[g];
               held <= PIN_RST[g];
            end else begin
               meta <= i_async[g];
               held <= meta;
            end
         end
         assign o_sync[g] = held;
      end
   endgenerate

endmodule

// File: core/dvs_pkg.sv
// constants, register map and state type of the serial control block
// assumes a single core clock domain; pins are synchronised before use
package dvs_pkg;

   // register addresses, seven bits after the read flag
   localparam logic [6:0] REG_REVISION   = 7'h00;
   localparam logic [6:0] REG_PART       = 7'h01;
   localparam logic [6:0] REG_SOFT_RESET = 7'h02;
   localparam logic [6:0] REG_POWER_DOWN = 7'h03;
   localparam logic [6:0] REG_A_BIAS     = 7'h04;
   localparam logic [6:0] REG_A_ATTEN    = 7'h05;
   localparam logic [6:0] REG_B_BIAS     = 7'h06;
   localparam logic [6:0] REG_B_ATTEN    = 7'h07;

   // identity values, arbitrary
   localparam logic [7:0] REVISION_CODE  = 8'h5A;
   localparam logic [7:0] PART_CODE      = 8'h3C;

   // field positions
   localparam int         BIT_CHAN_A     = 0;
   localparam int         BIT_CHAN_B     = 4;
   localparam int         BIT_READ_FLAG  = 15;
   localparam int         ATTEN_W        = 6;

   // reset values
   localparam logic [7:0] BIAS_RST       = 8'h20;
   localparam logic [5:0] ATTEN_RST      = 6'h14;

   // frame bit counts
   localparam logic [3:0] CNT_ADDR_LAST  = 4'h7;
   localparam logic [3:0] CNT_DATA_FIRST = 4'h8;
   localparam logic [3:0] CNT_FRAME_LAST = 4'hF;

   // pin synchroniser lanes and their reset levels
   localparam int         PIN_CS_B       = 0;
   localparam int         PIN_SCLK       = 1;
   localparam int         PIN_SDI        = 2;
   localparam int         PIN_SLEEP_A    = 3;
   localparam int         PIN_SLEEP_B    = 4;
   localparam int         PIN_W          = 5;
   localparam logic [4:0] PIN_RST        = 5'h01;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b01,
      ST_SHIFT = 2'b10
   } dvs_fsm_t;

   typedef struct packed {
      dvs_fsm_t    fsm;
      logic        sclk_prev;
      logic [3:0]  bit_cnt;
      logic [14:0] shift;
      logic        rd_act;
      logic [7:0]  sdo_shift;
      logic        sdo_oe;
      logic [7:0]  bias_a;
      logic [7:0]  bias_b;
      logic [5:0]  atten_a;
      logic [5:0]  atten_b;
      logic        pd_a;
      logic        pd_b;
      logic        sleep_a;
      logic        sleep_b;
      logic [3:0]  lvl_a;
      logic [3:0]  lvl_b;
   } dvs_state_t;

   localparam logic [3:0] LVL_RST = 4'h6;

   localparam dvs_state_t ST_RESET = '{
      fsm:       ST_IDLE,
      sclk_prev: 1'b0,
      bit_cnt:   4'h0,
      shift:     15'h0000,
      rd_act:    1'b0,
      sdo_shift: 8'h00,
      sdo_oe:    1'b0,
      bias_a:    BIAS_RST,
      bias_b:    BIAS_RST,
      atten_a:   ATTEN_RST,
      atten_b:   ATTEN_RST,
      pd_a:      1'b0,
      pd_b:      1'b0,
      sleep_a:   1'b0,
      sleep_b:   1'b0,
      lvl_a:     LVL_RST,
      lvl_b:     LVL_RST
   };

endpackage

// File: core/dvs_serial_ctrl.sv
// serial register port and channel control of a dual gain amplifier
// assumes the host is serial master; all pins are asynchronous to the clock
`timescale 1ns/1ps

// Summary of operation
// - shifting only happens while chip select is low
// - serial input is sampled on each rising serial clock edge
// - every sixteenth rising edge commits a write frame to its register; a read frame writes nothing
// - a partial frame at chip select rise is dropped
// - several frames may follow within one chip select period
// - each frame is address byte first, then data byte
// - any serial clock up to 25 MHz works if its high and low times each last over a core clock period
// - read frames return the addressed register on the serial output
// - reset loads every register default
// - address 2 holds self-clearing reset bits, B at bit 4, A at 0
// - writing one resets that channel's registers, zero does nothing
// - address 3 holds power-down bits, B at bit 4, A at 0
// - an active-high pin per channel also powers it down
// - register contents are preserved during power-down
// - bias registers at 4 and 6 reset to 20 hex
// - attenuator registers at 5 and 7 reset to 14 hex
// - each channel has its own 6-bit attenuation code
// - each attenuation step is one decibel
// - bias register selects one of the reduced power options
// - device reset or channel soft reset restores bias and attenuator defaults
// - attenuator upper two bits read as zero
// - bias default has bit 5 set; bit 7 is highest power
module dvs_serial_ctrl
   import dvs_pkg::*;
(
   input  wire logic         i_core_clk,
   input  wire logic         i_rst_b,
   input  wire logic         i_cs_b,
   input  wire logic         i_sclk,
   input  wire logic         i_sdi,
   input  wire logic         i_chan_a_sleep_pin,
   input  wire logic         i_chan_b_sleep_pin,
   output logic              o_sdo,
   output logic              o_sdo_oe,
   output logic      [7:0]   o_chan_a_bias_bus,
   output logic      [5:0]   o_chan_a_atten_bus,
   output logic      [7:0]   o_chan_b_bias_bus,
   output logic      [5:0]   o_chan_b_atten_bus,
   output logic              o_chan_a_sleep,
   output logic              o_chan_b_sleep,
   output logic      [3:0]   o_chan_a_power_lvl,
   output logic      [3:0]   o_chan_b_power_lvl
);

   logic [1:0]       rst_pipe;
   logic             rst_n;
   logic [PIN_W-1:0] pins_async;
   logic [PIN_W-1:0] pins;
   logic             cs_act;
   logic             sclk_s;
   logic             sdi_s;
   logic             sclk_rise;
   logic             sclk_fall;
   logic             in_shift;
   logic             addr_done;
   logic             commit;
   logic [7:0]       addr_byte;
   logic [15:0]      frame;
   logic [6:0]       wr_addr;
   logic [7:0]       wr_data;
   logic [7:0]       rd_byte;
   dvs_state_t       st;
   dvs_state_t       next_st;

   // reset release through two flip-flops
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_pipe <= 2'b00;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   assign pins_async[PIN_CS_B]    = i_cs_b;
   assign pins_async[PIN_SCLK]    = i_sclk;
   assign pins_async[PIN_SDI]     = i_sdi;
   assign pins_async[PIN_SLEEP_A] = i_chan_a_sleep_pin;
   assign pins_async[PIN_SLEEP_B] = i_chan_b_sleep_pin;

   dvs_pin_sync u_sync (
      .i_core_clk (i_core_clk),
      .i_rst_n    (rst_n),
      .i_async    (pins_async),
      .o_sync     (pins)
   );

   // power option: one plus index of highest set bias bit, zero for all clear
   function automatic logic [3:0] power_level(input logic [7:0] b);
      logic [3:0] lvl;
      lvl = 4'h0;
      casez (b)
         8'b1???_????: lvl = 4'h8;
         8'b01??_????: lvl = 4'h7;
         8'b001?_????: lvl = 4'h6;
         8'b0001_????: lvl = 4'h5;
         8'b0000_1???: lvl = 4'h4;
         8'b0000_01??: lvl = 4'h3;
         8'b0000_001?: lvl = 4'h2;
         8'b0000_0001: lvl = 4'h1;
         default:      lvl = 4'h0;
      endcase
      return lvl;
   endfunction

   function automatic logic [7:0] rd_data(input logic [6:0] a,
                                          input dvs_state_t s);
      logic [7:0] r;
      r = 8'h00;
      case (a)
         REG_REVISION:   r = REVISION_CODE;
         REG_PART:       r = PART_CODE;
         REG_SOFT_RESET: r = 8'h00;
         REG_POWER_DOWN: begin
            r[BIT_CHAN_A] = s.pd_a;
            r[BIT_CHAN_B] = s.pd_b;
         end
         REG_A_BIAS:     r = s.bias_a;
         REG_A_ATTEN:    r = {2'b00, s.atten_a};
         REG_B_BIAS:     r = s.bias_b;
         REG_B_ATTEN:    r = {2'b00, s.atten_b};
         default:        r = 8'h00;
      endcase
      return r;
   endfunction

   // edges found by the core clock while each serial clock level lasts over a core clock period
   assign cs_act    = ~pins[PIN_CS_B];
   assign sclk_s    = pins[PIN_SCLK];
   assign sdi_s     = pins[PIN_SDI];
   assign sclk_rise = sclk_s & ~st.sclk_prev;
   assign sclk_fall = ~sclk_s & st.sclk_prev;
   assign in_shift  = (st.fsm == ST_SHIFT) & cs_act;
   assign addr_done = in_shift & sclk_rise
                      & (st.bit_cnt == CNT_ADDR_LAST);
   assign commit    = in_shift & sclk_rise
                      & (st.bit_cnt == CNT_FRAME_LAST);
   assign addr_byte = {st.shift[6:0], sdi_s};
   assign frame     = {st.shift, sdi_s};
   assign wr_addr   = frame[14:8];
   assign wr_data   = frame[7:0];
   assign rd_byte   = rd_data(addr_byte[6:0], st);

   always_comb begin
      next_st           = st;
      next_st.sclk_prev = sclk_s;
      case (st.fsm)
         ST_IDLE: begin
            next_st.bit_cnt = 4'h0;
            if (cs_act) begin
               next_st.fsm    = ST_SHIFT;
               next_st.sdo_oe = 1'b1;
            end
         end
         ST_SHIFT: begin
            if (!cs_act) begin
               // trailing bits dropped with no effect
               next_st.fsm       = ST_IDLE;
               next_st.bit_cnt   = 4'h0;
               next_st.sdo_oe    = 1'b0;
               next_st.rd_act    = 1'b0;
               next_st.sdo_shift = 8'h00;
            end else if (sclk_rise) begin
               next_st.shift   = {st.shift[13:0], sdi_s};
               next_st.bit_cnt = 4'(st.bit_cnt + 4'h1);
               if (addr_done && addr_byte[7]) begin
                  next_st.rd_act    = 1'b1;
                  next_st.sdo_shift = rd_byte;
               end
               if (commit) begin
                  next_st.rd_act    = 1'b0;
                  next_st.sdo_shift = 8'h00;
               end
            end else if (sclk_fall && st.rd_act
                         && st.bit_cnt != CNT_DATA_FIRST) begin
               next_st.sdo_shift = {st.sdo_shift[6:0], 1'b0};
            end
         end
         default: begin
            next_st = ST_RESET;
         end
      endcase

      // writes land even in power-down; nothing is lost there
      if (commit && !frame[BIT_READ_FLAG]) begin
         case (wr_addr)
            REG_SOFT_RESET: begin
               if (wr_data[BIT_CHAN_A]) begin
                  next_st.bias_a  = BIAS_RST;
                  next_st.atten_a = ATTEN_RST;
               end
               if (wr_data[BIT_CHAN_B]) begin
                  next_st.bias_b  = BIAS_RST;
                  next_st.atten_b = ATTEN_RST;
               end
            end
            REG_POWER_DOWN: begin
               next_st.pd_a = wr_data[BIT_CHAN_A];
               next_st.pd_b = wr_data[BIT_CHAN_B];
            end
            REG_A_BIAS:  next_st.bias_a  = wr_data;
            REG_A_ATTEN: next_st.atten_a = wr_data[ATTEN_W-1:0];
            REG_B_BIAS:  next_st.bias_b  = wr_data;
            REG_B_ATTEN: next_st.atten_b = wr_data[ATTEN_W-1:0];
            default: begin
            end
         endcase
      end

      next_st.sleep_a = pins[PIN_SLEEP_A] | st.pd_a;
      next_st.sleep_b = pins[PIN_SLEEP_B] | st.pd_b;
      next_st.lvl_a   = power_level(next_st.bias_a);
      next_st.lvl_b   = power_level(next_st.bias_b);
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   // attenuation code is the loss in whole decibels
   assign o_sdo              = st.sdo_shift[7];
   assign o_sdo_oe           = st.sdo_oe;
   assign o_chan_a_bias_bus  = st.bias_a;
   assign o_chan_a_atten_bus = st.atten_a;
   assign o_chan_b_bias_bus  = st.bias_b;
   assign o_chan_b_atten_bus = st.atten_b;
   assign o_chan_a_sleep     = st.sleep_a;
   assign o_chan_b_sleep     = st.sleep_b;
   assign o_chan_a_power_lvl = st.lvl_a;
   assign o_chan_b_power_lvl = st.lvl_b;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!rst_n);

   oe_follows_cs_a: assert property (
      o_sdo_oe == $past(cs_act))
      else $error("serial output enable does not follow chip select");

   idle_no_count_a: assert property (
      !cs_act |=> st.bit_cnt == 4'h0)
      else $error("bit count moved while chip select high");

   sample_rise_a: assert property (
      (in_shift && sclk_rise) |=> st.shift[0] == $past(sdi_s))
      else $error("serial input not sampled on rising edge");

   commit_bias_a: assert property (
      (commit && !frame[BIT_READ_FLAG] && wr_addr == REG_A_BIAS)
      |=> o_chan_a_bias_bus == $past(wr_data))
      else $error("bias write not committed on sixteenth edge");

   partial_drop_a: assert property (
      (st.fsm == ST_SHIFT && !cs_act) |=>
      $stable(st.bias_a) && $stable(st.atten_a) && $stable(st.pd_a))
      else $error("partial frame changed a register");

   read_first_bit_a: assert property (
      (addr_done && addr_byte[7]) |=> o_sdo == $past(rd_byte[7])
      ##1 (o_sdo == $past(rd_byte[7], 2)))
      else $error("read data msb not presented after address");

   soft_reset_a: assert property (
      (commit && !frame[BIT_READ_FLAG] && wr_addr == REG_SOFT_RESET
       && wr_data[BIT_CHAN_A]) |=>
      st.bias_a == BIAS_RST && st.atten_a == ATTEN_RST)
      else $error("channel soft reset did not restore defaults");

   sleep_pin_a: assert property (
      ##1 o_chan_b_sleep == $past(pins[PIN_SLEEP_B] | st.pd_b))
      else $error("channel sleep output wrong");

   hold_sleep_a: assert property (
      (o_chan_a_sleep && !commit) |=> $stable(st.bias_b)
      && $stable(st.atten_b))
      else $error("register changed during power-down without write");

   reserved_read_a: assert property (
      (addr_done && addr_byte[7] && addr_byte[6:0] > REG_B_ATTEN)
      |=> st.sdo_shift == 8'h00)
      else $error("reserved address read not zero");

   reset_default_a: assert property (
      $rose(rst_n) |-> st.bias_a == BIAS_RST && st.atten_b == ATTEN_RST)
      else $error("defaults not loaded at reset");

   cover_write_c:  cover property (commit && !frame[BIT_READ_FLAG]);
   cover_read_c:   cover property (addr_done && addr_byte[7]);
   cover_stream_c: cover property (commit ##[1:1000] commit);
   cover_sleep_c:  cover property (o_chan_a_sleep && o_chan_b_sleep);

endmodule

// File: tb/dvs_host_model.sv
// host model: serial master driving chip select, clock and data
// assumes the bench calls sel and shift; clock idles low between frames
`timescale 1ns/1ps
module dvs_host_model (
   output logic      o_cs_b,
   output logic      o_sclk,
   output logic      o_sdi,
   input  wire logic i_sdo
);
   real hi_ns = 62.5;

   initial begin
      o_cs_b = 1'b1;
      o_sclk = 1'b0;
      o_sdi  = 1'b0;
   end

   // chip select held low over whole transfers
   task automatic sel(input logic on);
      #62.5;
      o_cs_b = ~on;
      o_sdi  = ~o_sdi;
      #62.5;
   endtask

   // msb first, address byte then data byte
   // n may span several frames high time set by hi_ns
   task automatic shift(input logic [15:0] w, input int n,
                        output logic [7:0] rd);
      rd = 8'h00;
      for (int i = 0; i < n; i++) begin
         o_sdi = w[15 - (i % 16)];
         #(125.0 - hi_ns);
         o_sclk = ~o_sclk;
         if ((i % 16) >= 8) rd = {rd[6:0], i_sdo};
         #(hi_ns);
         o_sclk = ~o_sclk;
      end
   endtask
endmodule

// File: tb/test_dual_vga_serial_control.sv
// self-checking bench of the serial control block
// assumes the host model drives the serial pins; bench drives reset, sleep
`timescale 1ns/1ps
module test_dual_vga_serial_control
   import dvs_pkg::*;
   ;
   typedef struct packed {
      logic [6:0]  adr;
      logic [7:0]  wd;
      logic [7:0]  rd;
      logic [31:0] bus;
      logic [1:0]  slp;
   } dvs_row_t;

   logic        clk = 1'b0;
   logic        rst_b;
   logic        slp_a;
   logic        slp_b;
   logic        cs_b;
   logic        sclk;
   logic        sdi;
   logic        sdo;
   logic        sdo_oe;
   logic        sdo_park = 1'b0;
   wire logic   sdo_w;
   logic [7:0]  bias_a;
   logic [7:0]  bias_b;
   logic [5:0]  att_a;
   logic [5:0]  att_b;
   logic [1:0]  slp_o;
   logic [3:0]  lvl_a;
   logic [3:0]  lvl_b;
   logic [7:0]  rd;
   wire logic [31:0] bus = {bias_a, 2'b00, att_a, bias_b, 2'b00, att_b};
   wire logic [31:0] misc = {16'h0000, lvl_b, lvl_a, 5'h00, sdo_oe, slp_o};
   int          miscompares = 0;
   int          n_tests = 0;
   int          cyc = 0;

   // written value, read-back and bus image after each write
   dvs_row_t rows [11] = '{
      '{7'h04, 8'hA5, 8'hA5, 32'hA514_2014, 2'b00},
      '{7'h05, 8'hFF, 8'h3F, 32'hA53F_2014, 2'b00},
      '{7'h06, 8'h81, 8'h81, 32'hA53F_8114, 2'b00},
      '{7'h07, 8'h2A, 8'h2A, 32'hA53F_812A, 2'b00},
      '{7'h00, 8'hFF, REVISION_CODE, 32'hA53F_812A, 2'b00},
      '{7'h01, 8'h00, PART_CODE, 32'hA53F_812A, 2'b00},
      '{7'h03, 8'hFF, 8'h11, 32'hA53F_812A, 2'b11},
      '{7'h03, 8'h00, 8'h00, 32'hA53F_812A, 2'b00},
      '{7'h02, 8'h00, 8'h00, 32'hA53F_812A, 2'b00},
      '{7'h08, 8'h77, 8'h00, 32'hA53F_812A, 2'b00},
      '{7'h7F, 8'h12, 8'h00, 32'hA53F_812A, 2'b00}
   };

   always #2 clk = ~clk;

   // released read line toggles so no stale level is seen
   assign sdo_w = sdo_oe ? sdo : sdo_park;
   always @(posedge clk) sdo_park <= ~sdo_w;

   dvs_host_model host_u (
      .o_cs_b (cs_b),
      .o_sclk (sclk),
      .o_sdi  (sdi),
      .i_sdo  (sdo_w)
   );

   dvs_serial_ctrl dut_u (
      .i_core_clk         (clk),
      .i_rst_b            (rst_b),
      .i_cs_b             (cs_b),
      .i_sclk             (sclk),
      .i_sdi              (sdi),
      .i_chan_a_sleep_pin (slp_a),
      .i_chan_b_sleep_pin (slp_b),
      .o_sdo              (sdo),
      .o_sdo_oe           (sdo_oe),
      .o_chan_a_bias_bus  (bias_a),
      .o_chan_a_atten_bus (att_a),
      .o_chan_b_bias_bus  (bias_b),
      .o_chan_b_atten_bus (att_b),
      .o_chan_a_sleep     (slp_o[0]),
      .o_chan_b_sleep     (slp_o[1]),
      .o_chan_a_power_lvl (lvl_a),
      .o_chan_b_power_lvl (lvl_b)
   );

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("compares %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // one whole frame in its own chip select period
   task automatic xfer(input logic r, input logic [6:0] a,
                       input logic [7:0] d);
      host_u.sel(1'b1);
      host_u.shift({r, a, d}, 16, rd);
      host_u.sel(1'b0);
      @(negedge clk);
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         miscompares++;
         end_sim();
      end
   end

   initial begin
      rst_b = 1'b0;
      slp_a = 1'b0;
      slp_b = 1'b0;
      repeat (12) @(negedge clk);
      chk(bus, 32'h2014_2014);
      chk(misc, 32'h0000_6600);
      rst_b = 1'b1;
      repeat (6) @(negedge clk);
      host_u.sel(1'b1);
      chk(misc, 32'h0000_6604);
      host_u.sel(1'b0);
      @(negedge clk);
      chk(misc, 32'h0000_6600);
      foreach (rows[k]) begin
         xfer(1'b0, rows[k].adr, rows[k].wd);
         xfer(1'b1, rows[k].adr, 8'h00);
         chk({24'h0, rd}, {24'h0, rows[k].rd});
         chk(bus, rows[k].bus);
         chk({30'h0, slp_o}, {30'h0, rows[k].slp});
      end
      chk(misc, 32'h0000_8800);
      // channel soft resets, one at a time
      xfer(1'b0, REG_SOFT_RESET, 8'h01);
      chk(bus, 32'h2014_812A);
      chk(misc, 32'h0000_8600);
      xfer(1'b0, REG_SOFT_RESET, 8'h10);
      chk(bus, 32'h2014_2014);
      xfer(1'b1, REG_SOFT_RESET, 8'h00);
      chk({24'h0, rd}, 32'h0000_0000);
      // sleep pins, with a write while asleep
      @(negedge clk);
      slp_a = 1'b1;
      repeat (8) @(negedge clk);
      chk({30'h0, slp_o}, 32'h0000_0001);
      xfer(1'b0, REG_B_ATTEN, 8'h05);
      slp_a = 1'b0;
      slp_b = 1'b1;
      repeat (8) @(negedge clk);
      chk({30'h0, slp_o}, 32'h0000_0002);
      slp_b = 1'b0;
      repeat (8) @(negedge clk);
      chk(bus, 32'h2014_2005);
      chk({30'h0, slp_o}, 32'h0000_0000);
      // two frames back to back, then a 15-bit tail
      host_u.sel(1'b1);
      host_u.shift({1'b0, REG_A_ATTEN, 8'h0A}, 16, rd);
      host_u.shift({1'b0, REG_B_BIAS, 8'h00}, 16, rd);
      host_u.shift({1'b0, REG_A_BIAS, 8'h33}, 15, rd);
      host_u.sel(1'b0);
      chk(bus, 32'h200A_0005);
      chk(misc, 32'h0000_0600);
      // short clock high time
      host_u.hi_ns = 20.0;
      xfer(1'b0, REG_B_ATTEN, 8'h27);
      host_u.hi_ns = 62.5;
      chk(bus, 32'h200A_0027);
      // read cut short, then a clean read
      host_u.sel(1'b1);
      host_u.shift({1'b1, REG_A_ATTEN, 8'h00}, 12, rd);
      host_u.sel(1'b0);
      @(negedge clk);
      chk(misc, 32'h0000_0600);
      xfer(1'b1, REG_A_ATTEN, 8'h00);
      chk({24'h0, rd}, 32'h0000_000A);
      // second reset in mid-run
      @(negedge clk);
      rst_b = 1'b0;
      repeat (3) @(negedge clk);
      chk(bus, 32'h2014_2014);
      chk(misc, 32'h0000_6600);
      rst_b = 1'b1;
      repeat (6) @(negedge clk);
      chk(misc, 32'h0000_6600);
      xfer(1'b1, REG_A_BIAS, 8'h00);
      chk({24'h0, rd}, {24'h0, BIAS_RST});
      end_sim();
   end
endmodule
